// ---- common/strap_if.sv ----
// carries the latched strap levels from sampler to decoder
// assumes both ends run on the same clock
`include "strap_params.svh"
interface strap_if;
  logic [`STRAP_COUNT-1:0] bits; // latched strap levels
  logic done; // high from the capture onward
  modport sampler (output bits, output done);
  modport decoder (input bits, input done);
endinterface

// ---- common/strap_params.svh ----
// constants for the basic pin mode strap decoder
// assumes a single 100 mhz clock; included by bare name wherever needed
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH

// number of sampled pins: ten straps plus the pin-mode select
`define STRAP_COUNT 11
// bit positions of each strap inside the sampled vector
`define IDX_DUPLEX 0
`define IDX_SPEED 1
`define IDX_AUTONEG 2
`define IDX_IFACE_MID 3
`define IDX_IFACE_LO 4
`define IDX_ISOLATE 5
`define IDX_ADDR0 6
`define IDX_ADDR1 7
`define IDX_ADDR2 8
`define IDX_IFACE_HI 9
`define IDX_PIN_MODE 10
// level of the pin-mode select that means basic mode
`define BASIC_MODE_LEVEL 1'h1
// settings shown before the straps are sampled (unstrapped levels)
`define DEF_ADDR 3'h1
`define DEF_AUTONEG 1'h1
`define DEF_SPEED 1'h1
`define DEF_DUPLEX_LEVEL 1'h1
`define DEF_ISOLATE 1'h0
// level of the duplex strap that selects full duplex
`define FULL_DUPLEX_LEVEL 1'h0
// strap settle time after reset release, and the clock period
`define SETTLE_NS 100
`define CLK_PERIOD_NS 10
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 4

`endif

// ---- common/strap_pkg.sv ----
// types shared by the strap sampler and the strap decoder
// assumes strap_params.svh is on the include path
`include "strap_params.svh"
package strap_pkg;
  // mac interface selection decoded from three straps
  typedef enum logic [1:0] {
    IFACE_MII,
    IFACE_RMII_MASTER,
    IFACE_RMII_SLAVE,
    IFACE_RESERVED
  } iface_mode_t;

  // power-up configuration produced by the decoder
  typedef struct packed {
    logic [2:0] mgmt_addr;
    iface_mode_t iface;
    logic autoneg_en;
    logic speed_100;
    logic full_duplex;
    logic mii_isolate;
  } cfg_t;

  // decoder states
  typedef enum logic [1:0] {
    ST_WAIT_SAMPLE,
    ST_BASIC,
    ST_ENHANCED
  } dec_state_t;
endpackage

// ---- hdl/basic_mode_strap_decoder.sv ----
// top of the basic pin mode strap decoder: turns latched straps into settings
// assumes board pulls hold the strap pins steady across reset release
// limitation: straps are read once per hard reset, later pin moves never reach the settings
`include "strap_params.svh"

//
// Contract
// - strap meanings apply only in basic mode
// - address bit0 from its strap, default 1
// - address bit1 from its strap, default 0
// - address bit2 from its strap, default 0
// - three straps select mii, rmii master, slave
// - autoneg strap 1 enables, default enabled
// - isolate strap 1 isolates mii, default off
// - sample at hard reset, reload on soft reset
// - each strap is one two-level bit
module basic_mode_strap_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // strap pins as seen at the package, already pulled by the board
  input wire logic addr_bit0_strap,
  input wire logic addr_bit1_strap,
  input wire logic addr_bit2_strap,
  input wire logic iface_sel_hi_strap,
  input wire logic iface_sel_mid_strap,
  input wire logic iface_sel_lo_strap,
  input wire logic autoneg_strap,
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic isolate_strap,
  input wire logic pin_mode_select,
  // management side, same clock
  input wire logic soft_reset,
  input wire logic cfg_write,
  input wire logic wr_autoneg_en,
  input wire logic wr_speed_100,
  input wire logic wr_full_duplex,
  input wire logic wr_mii_isolate,
  // decoded settings
  output logic [2:0] mgmt_addr,
  output strap_pkg::iface_mode_t iface_mode,
  output logic autoneg_en,
  output logic speed_100,
  output logic full_duplex,
  output logic mii_isolate,
  // status
  output logic cfg_valid,
  output logic basic_mode,
  output logic iface_reserved
);
  import strap_pkg::*;

  // whole state of the decoder
  typedef struct packed {
    dec_state_t st; // where the decoder stands
    cfg_t cfg; // live settings
    logic valid; // settings came from straps
    logic basic; // device is in basic pin mode
    logic reserved; // interface straps hit a reserved code
  } dec_reg_t;

  // q is the registered state, d its next value; both move as one block
  dec_reg_t q, d;

  // pins gathered into one vector, placed by the index constants
  logic [`STRAP_COUNT-1:0] pins;

  // latched strap levels from the sampler
  // only captured, settled levels cross here; no raw pin reaches the decoder
  strap_if sif ();

  // pin vector; each strap is a single two-level bit
  // wiring only: the sampler's first flop is the sole reader of these levels
  always_comb begin
    pins = '0;
    pins[`IDX_DUPLEX] = duplex_strap;
    pins[`IDX_SPEED] = speed_strap;
    pins[`IDX_AUTONEG] = autoneg_strap;
    pins[`IDX_IFACE_MID] = iface_sel_mid_strap;
    pins[`IDX_IFACE_LO] = iface_sel_lo_strap;
    pins[`IDX_ISOLATE] = isolate_strap;
    pins[`IDX_ADDR0] = addr_bit0_strap;
    pins[`IDX_ADDR1] = addr_bit1_strap;
    pins[`IDX_ADDR2] = addr_bit2_strap;
    pins[`IDX_IFACE_HI] = iface_sel_hi_strap;
    pins[`IDX_PIN_MODE] = pin_mode_select;
  end

  // synchroniser and one-shot capture live in the sampler
  strap_sampler u_sampler (
    .clock(clock),
    .rst_n(rst_n),
    .strap_pins(pins),
    .sif(sif)
  );

  // interface selection from hi, mid, lo strap levels
  function automatic iface_mode_t decode_iface(input logic hi, input logic mid, input logic lo);
    iface_mode_t m;
    // three codes are defined; every other pattern is flagged, never guessed
    m = IFACE_RESERVED;
    if (!hi && !mid && !lo) begin
      m = IFACE_MII;
    end else if (!hi && !mid && lo) begin
      m = IFACE_RMII_MASTER;
    end else if (hi && !mid && lo) begin
      m = IFACE_RMII_SLAVE;
    end
    return m;
  endfunction

  // full settings from a latched strap vector
  function automatic cfg_t decode_straps(input logic [`STRAP_COUNT-1:0] s);
    cfg_t c;
    // address bits keep their strap level, no inversion
    c.mgmt_addr[0] = s[`IDX_ADDR0];
    c.mgmt_addr[1] = s[`IDX_ADDR1];
    c.mgmt_addr[2] = s[`IDX_ADDR2];
    // the interface code is read from three pins as one field
    c.iface = decode_iface(s[`IDX_IFACE_HI], s[`IDX_IFACE_MID], s[`IDX_IFACE_LO]);
    c.autoneg_en = s[`IDX_AUTONEG];
    c.speed_100 = s[`IDX_SPEED];
    // a high duplex level means half duplex, so the unstrapped part is half
    c.full_duplex = (s[`IDX_DUPLEX] == `FULL_DUPLEX_LEVEL);
    c.mii_isolate = s[`IDX_ISOLATE];
    return c;
  endfunction

  // settings shown until the straps are known, equal to the unstrapped levels
  function automatic cfg_t default_cfg();
    cfg_t c;
    c.mgmt_addr = `DEF_ADDR;
    c.iface = IFACE_MII;
    c.autoneg_en = `DEF_AUTONEG;
    c.speed_100 = `DEF_SPEED;
    c.full_duplex = (`DEF_DUPLEX_LEVEL == `FULL_DUPLEX_LEVEL);
    // must match the levels of a part with no board resistors fitted
    c.mii_isolate = `DEF_ISOLATE;
    return c;
  endfunction

  // reset value as a constant, so the async reset branch loads no logic
  localparam cfg_t reset_cfg = default_cfg();

  // next state
  always_comb begin
    d = q;
    // one state per capture outcome; no way back short of a hard reset
    unique case (q.st)
      // wait for the one-shot capture after hard reset
      ST_WAIT_SAMPLE: begin
        if (sif.done) begin
          if (sif.bits[`IDX_PIN_MODE] == `BASIC_MODE_LEVEL) begin
            d.st = ST_BASIC;
            d.basic = 1'h1;
            d.cfg = decode_straps(sif.bits);
            d.valid = 1'h1;
            // a reserved code still loads the other fields, so the part stays reachable
            d.reserved = (decode_iface(sif.bits[`IDX_IFACE_HI], sif.bits[`IDX_IFACE_MID],
                                       sif.bits[`IDX_IFACE_LO]) == IFACE_RESERVED);
          end else begin
            // other strap meanings belong to a different decoder; hold defaults
            d.st = ST_ENHANCED;
          end
        end
      end
      // basic mode: soft reset reloads from the stored capture, never the pins
      ST_BASIC: begin
        // a reload beats a write in the same cycle
        if (soft_reset) begin
          d.cfg = decode_straps(sif.bits);
        end else if (cfg_write) begin
          // management may override the strap values until the next reset
          // address and interface stay as strapped
          d.cfg.autoneg_en = wr_autoneg_en;
          d.cfg.speed_100 = wr_speed_100;
          d.cfg.full_duplex = wr_full_duplex;
          d.cfg.mii_isolate = wr_mii_isolate;
        end
      end
      // not basic mode: nothing here to drive
      // writes and reloads are ignored here, settings stay at their reset values
      ST_ENHANCED: begin
        d.st = ST_ENHANCED;
      end
      // illegal code: return to a safe wait
      default: begin
        d.st = ST_WAIT_SAMPLE;
      end
    endcase
  end

  // register; outputs come straight from these flops
  // async reset shows the unstrapped settings at once, before any clock runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q.st <= ST_WAIT_SAMPLE;
      q.cfg <= reset_cfg;
      q.valid <= 1'h0;
      q.basic <= 1'h0;
      q.reserved <= 1'h0;
    end else begin
      q <= d;
    end
  end

  // outputs: plain copies of q, no gating after the flops
  // settings
  assign mgmt_addr = q.cfg.mgmt_addr;
  assign iface_mode = q.cfg.iface;
  assign autoneg_en = q.cfg.autoneg_en;
  assign speed_100 = q.cfg.speed_100;
  assign full_duplex = q.cfg.full_duplex;
  assign mii_isolate = q.cfg.mii_isolate;
  // status
  assign cfg_valid = q.valid;
  assign basic_mode = q.basic;
  assign iface_reserved = q.reserved;
endmodule // basic_mode_strap_decoder

// ---- hdl/strap_sampler.sv ----
// synchronises the strap pins and latches them once after hard reset
// assumes the pins are static while the device leaves reset
`include "strap_params.svh"
module strap_sampler (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // raw strap pins from the board
  input wire logic [`STRAP_COUNT-1:0] strap_pins,
  // latched levels toward the decoder
  strap_if.sampler sif
);
  import strap_pkg::*;

  // whole state of the sampler
  typedef struct packed {
    logic [`STRAP_COUNT-1:0] sync1; // first synchroniser stage
    logic [`STRAP_COUNT-1:0] sync2; // second synchroniser stage
    logic [`SETTLE_CNT_W-1:0] cnt; // settle counter
    logic [`STRAP_COUNT-1:0] bits; // latched levels
    logic done; // capture has happened
  } samp_state_t;

  samp_state_t q, d;

  // next state: capture happens once, then the value is frozen for reloads
  always_comb begin
    d = q;
    d.sync1 = strap_pins;
    d.sync2 = q.sync1;
    if (!q.done) begin
      if (q.cnt == `SETTLE_CNT_W'(`SETTLE_CYCLES)) begin
        d.bits = q.sync2;
        d.done = 1'h1;
      end else begin
        d.cnt = q.cnt + `SETTLE_CNT_W'(1);
      end
    end
  end

  // register; reset loads constants only, the pins are caught after release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.bits = q.bits;
  assign sif.done = q.done;
endmodule // strap_sampler

// ---- sim/board_pulls.sv ----
// partner model: board resistors on the strap pins
// assumes the bench fits a resistor only where fitted is set
module board_pulls (
  // wanted levels and fitted resistors
  input wire logic [10:0] want,
  input wire logic [10:0] fitted,
  // levels at the pins
  output logic [10:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // an open pin settles to its internal pull, never floats
  localparam logic [10:0] def_lvl = 11'h5c1;
  // two levels per pin only
  assign pins = (want & fitted) | (def_lvl & ~fitted);
endmodule // board_pulls

// ---- sim/strap_monitor.sv ----
// checker on the decoder's top ports
// assumes one clock and async active low reset
module strap_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // mode and management inputs
  input wire logic pin_mode_select,
  input wire logic soft_reset,
  input wire logic cfg_write,
  input wire logic wr_autoneg_en,
  input wire logic wr_speed_100,
  input wire logic wr_full_duplex,
  input wire logic wr_mii_isolate,
  // decoded outputs
  input wire logic [2:0] mgmt_addr,
  input wire strap_pkg::iface_mode_t iface_mode,
  input wire logic autoneg_en,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic mii_isolate,
  input wire logic cfg_valid,
  input wire logic basic_mode,
  input wire logic iface_reserved
);
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  wire [3:0] flds = {autoneg_en, speed_100, full_duplex, mii_isolate}; // writable settings
  wire [3:0] wrb = {wr_autoneg_en, wr_speed_100, wr_full_duplex, wr_mii_isolate}; // write data
  logic [3:0] cap_q; // settings as first loaded
  logic seen_q; // load already recorded
  // keep the load so a soft reload can be judged after writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'h0;
      cap_q <= 4'h0;
    end else if (cfg_valid && !seen_q) begin
      seen_q <= 1'h1;
      cap_q <= flds;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_quiet; (!cfg_valid)[*8]; endsequence
  sequence s_up; cfg_valid && basic_mode; endsequence
  property p_reset; $rose(rst_n) |-> mgmt_addr == 3'h1 && iface_mode == IFACE_MII && flds == 4'hc && !cfg_valid;
  endproperty
  property p_load; $rose(rst_n) && pin_mode_select |-> s_quiet ##[2:8] s_up; endproperty
  property p_nobasic; $rose(rst_n) && !pin_mode_select |-> s_quiet ##8 !basic_mode; endproperty
  property p_idle; !basic_mode |-> !cfg_valid && mgmt_addr == 3'h1 && flds == 4'hc; endproperty
  property p_valid; cfg_valid |-> basic_mode && iface_reserved == (iface_mode == IFACE_RESERVED); endproperty
  property p_write; cfg_write && !soft_reset && cfg_valid |=> flds == $past(wrb) && $stable(mgmt_addr); endproperty
  property p_soft; soft_reset && seen_q |=> flds == cap_q; endproperty
  property p_hold; cfg_valid && !cfg_write && !soft_reset |=> $stable(flds) && $stable(iface_mode); endproperty
  a_reset: assert property (p_reset) else $error("bad settings after reset");
  a_load: assert property (p_load) else $error("straps not loaded in time");
  a_nobasic: assert property (p_nobasic) else $error("enhanced pin mode loaded");
  a_idle: assert property (p_idle) else $error("settings moved outside basic mode");
  a_valid: assert property (p_valid) else $error("status flags disagree");
  a_write: assert property (p_write) else $error("write not applied");
  a_soft: assert property (p_soft) else $error("soft reload wrong");
  a_hold: assert property (p_hold) else $error("settings moved unasked");
endmodule // strap_monitor
bind basic_mode_strap_decoder strap_monitor u_mon (.clock(clock), .rst_n(rst_n),
  .pin_mode_select(pin_mode_select), .soft_reset(soft_reset), .cfg_write(cfg_write),
  .wr_autoneg_en(wr_autoneg_en), .wr_speed_100(wr_speed_100), .wr_full_duplex(wr_full_duplex),
  .wr_mii_isolate(wr_mii_isolate), .mgmt_addr(mgmt_addr), .iface_mode(iface_mode), .autoneg_en(autoneg_en),
  .speed_100(speed_100), .full_duplex(full_duplex), .mii_isolate(mii_isolate), .cfg_valid(cfg_valid),
  .basic_mode(basic_mode), .iface_reserved(iface_reserved));

// ---- sim/tb_basic_mode_strap_decoder.sv ----
// bench: random strap sets, hard resets, writes and soft reloads
// assumes board_pulls and the bound checker are compiled first
module tb_basic_mode_strap_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  logic clock, rst_n, soft_reset, cfg_write, basic;
  logic [3:0] wr; // write data: autoneg, speed, duplex, isolate
  logic [10:0] want, fitted, pins;
  wire [2:0] stat; // status outputs, one port per bit
  logic [2:0] c; // interface code
  wire cfg_t got; // settings as the design shows them
  cfg_t cap, ex; // expected settings
  logic [2:0] code [3] = '{3'h0, 3'h1, 3'h5}; // legal interface codes only
  int miscompares = 0;
  int cmp_count = 0;
  board_pulls u_pulls (.want(want), .fitted(fitted), .pins(pins));
  basic_mode_strap_decoder u_dut (.clock(clock), .rst_n(rst_n), .addr_bit0_strap(pins[0]),
    .addr_bit1_strap(pins[1]), .addr_bit2_strap(pins[2]), .iface_sel_hi_strap(pins[3]),
    .iface_sel_mid_strap(pins[4]), .iface_sel_lo_strap(pins[5]), .autoneg_strap(pins[6]),
    .speed_strap(pins[7]), .duplex_strap(pins[8]), .isolate_strap(pins[9]), .pin_mode_select(pins[10]),
    .soft_reset(soft_reset), .cfg_write(cfg_write), .wr_autoneg_en(wr[3]), .wr_speed_100(wr[2]),
    .wr_full_duplex(wr[1]), .wr_mii_isolate(wr[0]), .mgmt_addr(got.mgmt_addr), .iface_mode(got.iface),
    .autoneg_en(got.autoneg_en), .speed_100(got.speed_100), .full_duplex(got.full_duplex),
    .mii_isolate(got.mii_isolate), .cfg_valid(stat[2]), .basic_mode(stat[1]), .iface_reserved(stat[0]));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  task chk_cfg(input cfg_t g, input cfg_t e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task chk_stat(input logic [2:0] g, input logic [2:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence: one hard reset per strap set, first one unstrapped
  initial begin
    {soft_reset, cfg_write, wr} = '0;
    void'($urandom(32'h85f5));
    for (int i = 0; i < 9; i++) begin
      want = {i % 4 != 3, 10'($urandom)};
      fitted = (i == 0) ? 11'h0 : 11'($urandom) | 11'h438;
      {want[3], want[4], want[5]} = code[i % 3];
      rst_n = 1'h0;
      repeat (5) @(negedge clock);
      rst_n = 1'h1;
      // expectation worked out from the settled pin levels
      basic = pins[10];
      c = {pins[3], pins[4], pins[5]};
      cap = '{pins[2:0], c == 3'h0 ? IFACE_MII : c == 3'h1 ? IFACE_RMII_MASTER : IFACE_RMII_SLAVE,
        pins[6], pins[7], !pins[8], pins[9]};
      if (!basic) cap = '{3'h1, IFACE_MII, 1'h1, 1'h1, 1'h0, 1'h0};
      repeat (14) @(negedge clock);
      chk_cfg(got, cap);
      chk_stat(stat, {basic, basic, 1'h0});
      // pins move after capture while new settings are written
      want = ~want;
      wr = 4'($urandom);
      cfg_write = 1'h1;
      @(negedge clock);
      ex = cap;
      if (basic) {ex.autoneg_en, ex.speed_100, ex.full_duplex, ex.mii_isolate} = wr;
      chk_cfg(got, ex);
      // write held high and soft reset together: the reload wins
      wr = ~wr;
      soft_reset = 1'h1;
      @(negedge clock);
      {cfg_write, soft_reset} = 2'h0;
      chk_cfg(got, cap);
      $display("test %0d done", i);
    end
    test_done;
  end
  // watchdog: nine tests need about 190 cycles
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    test_done;
  end
endmodule // tb_basic_mode_strap_decoder
